/* File: hw/mcu_regs.svh */
// register offsets, field positions, command codes and memory constants
`ifndef MCU_REGS_SVH
`define MCU_REGS_SVH

// register byte offsets on the bus
`define MCU_CTRL_OFS        8'h00
`define MCU_STATUS_OFS      8'h04
`define MCU_HOLD_OFS        8'h08
`define MCU_BANK_OFS        8'h0c

// control register fields
`define MCU_CTRL_WAIT_LSB   0
`define MCU_CTRL_WAIT_MSB   3
`define MCU_CTRL_RESET      4'h2

// status register bit positions
`define MCU_ST_GLOBAL       0
`define MCU_ST_SPECIAL      1
`define MCU_ST_PEND_GLOBAL  2
`define MCU_ST_PEND_SPECIAL 3
`define MCU_ST_BUSY         4

// command codes held in operand digit 4
`define MCU_CMD_WR_LOG      4'h2
`define MCU_CMD_RD_LOG      4'h3
`define MCU_CMD_WR_PHY      4'h4
`define MCU_CMD_RD_PHY      4'h5
`define MCU_CMD_GLOBAL_OFF  4'h6
`define MCU_CMD_GLOBAL_ON   4'h7
`define MCU_CMD_SPECIAL_OFF 4'he
`define MCU_CMD_SPECIAL_ON  4'hf

// translation entry page, entry word layout and bank select reset value
`define MCU_ENTRY_BASE      24'h804000
`define MCU_ENTRY_EN_BIT    15
`define MCU_BANK_RESET      2'h0

// default physical pages when translation does not apply
`define MCU_PAGE5_BANK1     12'h006
`define MCU_PAGE5_OTHER     12'h005

// highest operating-system page number
`define MCU_OS_LAST_PAGE    4'h2

`endif

/* File: hw/mcu_pkg.sv */
// types shared by the memory command unit
package mcu_pkg;
  // command sequencer states
  typedef enum logic [2:0] {
    S_IDLE,
    S_ENT,
    S_ENT_WT,
    S_DATA,
    S_DATA_WT
  } mcu_state_t;
endpackage : mcu_pkg

/* File: hw/mcu_mem_port.sv */
// one word access to the external flash/ram, with stretchable strobes
`timescale 1ns/1ps
`include "mcu_regs.svh"

module mcu_mem_port (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic        write,
  input  wire logic [23:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [3:0]  wait_cycles,
  output logic             done,
  output logic [15:0]      rdata,
  output logic [23:0]      mem_addr,
  output logic             mem_cs0_n,
  output logic             mem_cs1_n,
  output logic             mem_oe_n,
  output logic             mem_we_n,
  output logic [15:0]      mem_dq_out,
  output logic             mem_dq_oe,
  input  wire logic [15:0] mem_dq_in
);
  logic        busy_reg;     // access in progress
  logic [4:0]  cnt_reg;      // cycles spent in the access
  logic        write_reg;    // direction of current access
  logic [15:0] sync1_reg;    // first synchroniser stage
  logic [15:0] sync2_reg;    // second synchroniser stage
  logic        last;         // final cycle of the access

  // two extra cycles cover the data-in synchroniser delay
  assign last = busy_reg && (cnt_reg == ({1'b0, wait_cycles} + 5'h02));

  //////////////////////////////////////////////////////////////////////////////
  // data-in synchroniser, pins are asynchronous to the clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
    end else if (ce) begin
      sync1_reg <= mem_dq_in;
      sync2_reg <= sync1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // access timing and strobes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_reg   <= 1'b0;
      cnt_reg    <= 5'h00;
      write_reg  <= 1'b0;
      mem_addr   <= 24'h000000;
      mem_cs0_n  <= 1'b1;
      mem_cs1_n  <= 1'b1;
      mem_oe_n   <= 1'b1;
      mem_we_n   <= 1'b1;
      mem_dq_out <= 16'h0000;
      mem_dq_oe  <= 1'b0;
      done       <= 1'b0;
      rdata      <= 16'h0000;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !busy_reg) begin
        // upper half of physical space is the ram chip select
        busy_reg   <= 1'b1;
        cnt_reg    <= 5'h00;
        write_reg  <= write;
        mem_addr   <= addr;
        mem_cs0_n  <= addr[23];
        mem_cs1_n  <= !addr[23];
        mem_oe_n   <= write;
        mem_we_n   <= !write;
        mem_dq_out <= wdata;
        mem_dq_oe  <= write;
      end else if (last) begin
        // release everything and hand back the word
        busy_reg  <= 1'b0;
        mem_cs0_n <= 1'b1;
        mem_cs1_n <= 1'b1;
        mem_oe_n  <= 1'b1;
        mem_we_n  <= 1'b1;
        mem_dq_oe <= 1'b0;
        done      <= 1'b1;
        if (!write_reg) begin
          rdata <= sync2_reg;
        end
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end
endmodule : mcu_mem_port

/* File: hw/mcu_mem_cmd.sv */
// memory command unit: translation control, memory commands, bank tracking
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "mcu_regs.svh"

module mcu_mem_cmd (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // memory command instruction from the cpu
  input  wire logic        cmd_valid,
  input  wire logic [55:0] cmd_operand,
  output logic             cmd_ready,
  input  wire logic [15:0] program_counter,
  // executed bank change seen on the instruction stream
  input  wire logic        bank_change,
  input  wire logic [3:0]  bank_change_page,
  input  wire logic [1:0]  bank_change_code,
  // external memory pins
  output logic [23:0]      mem_addr,
  output logic             mem_cs0_n,
  output logic             mem_cs1_n,
  output logic             mem_oe_n,
  output logic             mem_we_n,
  output logic [15:0]      mem_dq_out,
  output logic             mem_dq_oe,
  input  wire logic [15:0] mem_dq_in
);
  //////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // bank digit low bits to bank index (0 = bank 1)
  function automatic logic [1:0] bank_index(input logic [1:0] code);
    case (code)
      2'h0:    bank_index = 2'h0;
      2'h1:    bank_index = 2'h2;
      2'h2:    bank_index = 2'h1;
      default: bank_index = 2'h3;
    endcase
  endfunction : bank_index

  // page to bank select slot, 7 means the page has one bank
  function automatic logic [2:0] bank_slot(input logic [3:0] page);
    case (page)
      4'h5:    bank_slot = 3'h0;
      4'h6:    bank_slot = 3'h1;
      4'h7:    bank_slot = 3'h2;
      4'h8,
      4'h9:    bank_slot = 3'h3;
      4'ha,
      4'hb:    bank_slot = 3'h4;
      4'hc,
      4'hd:    bank_slot = 3'h5;
      4'he,
      4'hf:    bank_slot = 3'h6;
      default: bank_slot = 3'h7;
    endcase
  endfunction : bank_slot

  // apb address hits a mapped register
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `MCU_CTRL_OFS) || (a == `MCU_STATUS_OFS) ||
              (a == `MCU_HOLD_OFS) || (a == `MCU_BANK_OFS);
  endfunction : reg_hit

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  mcu_pkg::mcu_state_t state_reg;      // sequencer state
  logic [55:0]         op_reg;         // accepted operand
  logic                global_reg;     // global translation on
  logic                special_reg;    // special translation on
  logic                pend_global;    // buffered global disable
  logic                pend_special;   // buffered special disable
  logic [11:0]         phys_page_reg;  // resolved physical page
  logic [15:0]         hold_reg;       // latched read word
  logic [3:0]          wait_reg;       // extra strobe cycles
  logic [1:0]          bank_reg [7];   // bank select per slot
  logic [3:0]          cmd_code;       // digit 4 of new operand
  logic [3:0]          op_code;        // digit 4 of held operand
  logic                accept;         // command taken this cycle
  logic                os_page;        // pc inside pages 0-2
  logic [3:0]          log_page;       // logical page of held op
  logic [1:0]          log_bank;       // decoded bank of held op
  logic                special_page;   // page 0-3 or 5
  logic                port_start;     // begin a memory access
  logic                port_write;     // access direction
  logic [23:0]         port_addr;      // access address
  logic                port_done;      // access finished
  logic [15:0]         port_rdata;     // word read back
  logic [11:0]         default_page;   // untranslated page

  assign cmd_code     = cmd_operand[19:16];
  assign op_code      = op_reg[19:16];
  assign cmd_ready    = (state_reg == mcu_pkg::S_IDLE);
  assign accept       = ce && cmd_valid && cmd_ready;
  assign os_page      = (program_counter[15:12] <= `MCU_OS_LAST_PAGE);
  assign log_page     = op_reg[39:36];
  assign log_bank     = bank_index(op_reg[21:20]);
  assign special_page = (log_page <= 4'h3) || (log_page == 4'h5);

  // fall-back location, used whenever no entry applies
  always_comb begin
    if (log_page == 4'h5) begin
      default_page = (log_bank == 2'h0) ? `MCU_PAGE5_BANK1 : `MCU_PAGE5_OTHER;
    end else begin
      default_page = {8'h00, log_page};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // translation enables; disables are buffered so the code that issued
  // them is not pulled out from under itself mid-routine
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      global_reg   <= 1'b0;
      special_reg  <= 1'b0;
      pend_global  <= 1'b0;
      pend_special <= 1'b0;
    end else if (ce) begin
      if (pend_global && os_page) begin
        global_reg  <= 1'b0;
        pend_global <= 1'b0;
      end
      if (pend_special && os_page) begin
        special_reg  <= 1'b0;
        pend_special <= 1'b0;
      end
      if (accept) begin
        case (cmd_code)
          `MCU_CMD_GLOBAL_ON: begin
            global_reg  <= 1'b1;
            pend_global <= 1'b0;
          end
          `MCU_CMD_SPECIAL_ON: begin
            special_reg  <= 1'b1;
            pend_special <= 1'b0;
          end
          `MCU_CMD_GLOBAL_OFF:  pend_global  <= 1'b1;
          `MCU_CMD_SPECIAL_OFF: pend_special <= 1'b1;
          default: ;  // other codes are handled elsewhere or ignored
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command sequencer: optional entry fetch, then the data access
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg     <= mcu_pkg::S_IDLE;
      op_reg        <= 56'h0;
      phys_page_reg <= 12'h000;
      hold_reg      <= 16'h0000;
    end else if (ce) begin
      case (state_reg)
        mcu_pkg::S_IDLE: begin
          if (accept) begin
            op_reg <= cmd_operand;
            case (cmd_code)
              `MCU_CMD_WR_LOG,
              `MCU_CMD_RD_LOG: state_reg <= mcu_pkg::S_ENT;
              `MCU_CMD_WR_PHY,
              `MCU_CMD_RD_PHY: state_reg <= mcu_pkg::S_DATA;
              default:         state_reg <= mcu_pkg::S_IDLE;
            endcase
          end
        end
        mcu_pkg::S_ENT: begin
          // special pages translate only with both enables set
          if (global_reg && (!special_page || special_reg)) begin
            state_reg <= mcu_pkg::S_ENT_WT;
          end else begin
            phys_page_reg <= default_page;
            state_reg     <= mcu_pkg::S_DATA;
          end
        end
        mcu_pkg::S_ENT_WT: begin
          if (port_done) begin
            // a disabled entry leaves the page at its default place
            phys_page_reg <= port_rdata[`MCU_ENTRY_EN_BIT] ?
                             port_rdata[11:0] : default_page;
            state_reg     <= mcu_pkg::S_DATA;
          end
        end
        mcu_pkg::S_DATA: state_reg <= mcu_pkg::S_DATA_WT;
        mcu_pkg::S_DATA_WT: begin
          if (port_done) begin
            if (!port_write) begin
              hold_reg <= port_rdata;
            end
            state_reg <= mcu_pkg::S_IDLE;
          end
        end
        default: state_reg <= mcu_pkg::S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // access request towards the memory port
  always_comb begin
    port_start = 1'b0;
    port_write = 1'b0;
    port_addr  = 24'h000000;
    if (state_reg == mcu_pkg::S_ENT) begin
      // one entry per page and bank, even on shared selects
      port_start = global_reg && (!special_page || special_reg);
      port_addr  = `MCU_ENTRY_BASE | {18'h0, log_page, log_bank};
    end else if (state_reg == mcu_pkg::S_DATA) begin
      port_start = 1'b1;
      port_write = (op_code == `MCU_CMD_WR_LOG) || (op_code == `MCU_CMD_WR_PHY);
      if ((op_code == `MCU_CMD_WR_PHY) || (op_code == `MCU_CMD_RD_PHY)) begin
        port_addr = op_reg[47:24];
      end else begin
        port_addr = {phys_page_reg, op_reg[35:24]};
      end
    end else if (state_reg == mcu_pkg::S_DATA_WT) begin
      // keep direction visible for the read latch decision
      port_write = (op_code == `MCU_CMD_WR_LOG) || (op_code == `MCU_CMD_WR_PHY);
    end
  end

  // the word-wide memory access itself; the regions holding registers
  // and entries are not fenced, software must take care there
  mcu_mem_port u_port (
    .clock       (clock),
    .rst         (rst),
    .ce          (ce),
    .start       (port_start),
    .write       (port_write),
    .addr        (port_addr),
    .wdata       (op_reg[15:0]),
    .wait_cycles (wait_reg),
    .done        (port_done),
    .rdata       (port_rdata),
    .mem_addr    (mem_addr),
    .mem_cs0_n   (mem_cs0_n),
    .mem_cs1_n   (mem_cs1_n),
    .mem_oe_n    (mem_oe_n),
    .mem_we_n    (mem_we_n),
    .mem_dq_out  (mem_dq_out),
    .mem_dq_oe   (mem_dq_oe),
    .mem_dq_in   (mem_dq_in)
  );

  //////////////////////////////////////////////////////////////////////////////
  // bank select registers, one per slot
  generate
    for (genvar s = 0; s < 7; s++) begin : g_bank
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          bank_reg[s] <= `MCU_BANK_RESET;
        end else if (ce && bank_change && (bank_slot(bank_change_page) == 3'(s))) begin
          bank_reg[s] <= bank_index(bank_change_code);
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states; read data registered in the setup cycle
  assign pready = 1'b1;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_reg <= `MCU_CTRL_RESET;
    end else if (ce && psel && penable && pwrite && (paddr == `MCU_CTRL_OFS)) begin
      wait_reg <= pwdata[`MCU_CTRL_WAIT_MSB:`MCU_CTRL_WAIT_LSB];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce && psel && !penable) begin
      pslverr <= !reg_hit(paddr);
      prdata  <= 32'h00000000;
      if (!pwrite) begin
        case (paddr)
          `MCU_CTRL_OFS:   prdata <= {28'h0, wait_reg};
          `MCU_STATUS_OFS: prdata <= {27'h0, !cmd_ready, pend_special, pend_global,
                                      special_reg, global_reg};
          `MCU_HOLD_OFS:   prdata <= {16'h0, hold_reg};
          `MCU_BANK_OFS:   prdata <= {18'h0, bank_reg[6], bank_reg[5], bank_reg[4],
                                      bank_reg[3], bank_reg[2], bank_reg[1], bank_reg[0]};
          default:         prdata <= 32'h00000000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  glob_on_a: assert property (@(posedge clock) disable iff (rst)
    accept && (cmd_code == `MCU_CMD_GLOBAL_ON) |=> global_reg)
    else $error("global enable command did not enable translation");

  spec_on_a: assert property (@(posedge clock) disable iff (rst)
    accept && (cmd_code == `MCU_CMD_SPECIAL_ON) |=> special_reg)
    else $error("special enable command did not enable special path");

  glob_hold_a: assert property (@(posedge clock) disable iff (rst)
    ce && global_reg && !os_page && !accept |=> global_reg)
    else $error("global translation dropped outside os pages");

  spec_off_a: assert property (@(posedge clock) disable iff (rst)
    ce && pend_special && os_page && !(accept && cmd_code == `MCU_CMD_SPECIAL_ON)
    |=> !special_reg)
    else $error("pending special disable not applied in os page");

  glob_off_a: assert property (@(posedge clock) disable iff (rst)
    accept && (cmd_code == `MCU_CMD_GLOBAL_OFF) |=> pend_global || !global_reg)
    else $error("global disable command was lost");

  spec_gate_a: assert property (@(posedge clock) disable iff (rst)
    ce && (state_reg == mcu_pkg::S_ENT) && special_page && !(special_reg && global_reg)
    |=> state_reg == mcu_pkg::S_DATA)
    else $error("special page translated without both enables");

  entry_addr_a: assert property (@(posedge clock) disable iff (rst)
    port_start && (state_reg == mcu_pkg::S_ENT) |-> port_addr[23:12] == 12'h804)
    else $error("entry fetch outside the entry page");

  phys_addr_a: assert property (@(posedge clock) disable iff (rst)
    accept && (cmd_code == `MCU_CMD_RD_PHY) ##1 ce |-> port_addr == $past(cmd_operand[47:24]))
    else $error("physical address not taken from digits 11-6");

  wr_data_a: assert property (@(posedge clock) disable iff (rst)
    ce && port_start && port_write ##1 ce |-> mem_dq_out == op_reg[15:0] && mem_dq_oe)
    else $error("write data not driven from digits 3-0");

  hold_latch_a: assert property (@(posedge clock) disable iff (rst)
    ce && port_done && !port_write && (state_reg == mcu_pkg::S_DATA_WT)
    |=> hold_reg == $past(port_rdata))
    else $error("read word not latched into holding register");
endmodule : mcu_mem_cmd

/* File: verif/mcu_mem_model.sv */
// behavioural word-wide flash and ram on the far side of the memory pins
`timescale 1ns/1ps

module mcu_mem_model (
  input  wire logic        clock,
  input  wire logic        slow,
  input  wire logic [23:0] mem_addr,
  input  wire logic        mem_cs0_n,
  input  wire logic        mem_cs1_n,
  input  wire logic        mem_oe_n,
  input  wire logic        mem_we_n,
  input  wire logic [15:0] mem_dq_out,
  input  wire logic        mem_dq_oe,
  output logic      [15:0] mem_dq_in
);
  logic [15:0] mem [int]; // sparse word store, both halves
  logic [15:0] last_q;    // last word driven, inverted once released
  int          dly;       // edges seen with output enable low
  logic        sel;       // the half picked by address bit 23 is selected
  logic        rd;        // read strobe on a selected half

  assign sel = mem_addr[23] ? !mem_cs1_n : !mem_cs0_n;
  assign rd  = sel && !mem_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // write on every strobe-low edge; count read latency
  always @(posedge clock) begin
    if (sel && !mem_we_n && mem_dq_oe) begin
      mem[mem_addr] = mem_dq_out;
    end
    if (rd && (!slow || dly > 2)) begin
      last_q = mem_dq_in;
    end
    dly = rd ? dly + 1 : 0;
  end

  // slow part holds back valid data; a released bus never shows the old word
  always @* begin
    if (rd && (!slow || dly > 2)) begin
      mem_dq_in = mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
    end else begin
      mem_dq_in = ~last_q;
    end
  end
endmodule : mcu_mem_model

/* File: verif/mcu_mem_cmd_tb.sv */
// self-checking bench for the memory command unit
`timescale 1ns/1ps
`include "mcu_regs.svh"

module mcu_mem_cmd_tb;
  logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdv, xbank;
  logic        pready, pslverr, erv, cmd_valid = 0, cmd_ready, slow = 0;
  logic [55:0] cmd_operand = 0;
  logic [15:0] program_counter = 16'h8000, mem_dq_out, mem_dq_in;
  logic        bank_change = 0, mem_cs0_n, mem_cs1_n, mem_oe_n, mem_we_n;
  logic [3:0]  bank_change_page = 0;
  logic [1:0]  bank_change_code = 0;
  logic [23:0] mem_addr;
  logic        mem_dq_oe;
  logic [15:0] xm [int];             // expected memory image
  int          bad_count = 0, n_compared = 0, seed = 32'h9884ce9d;

  always #5 clock = ~clock;

  mcu_mem_cmd mcu_mem_cmd_i (.clock(clock), .rst(rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid),
    .cmd_operand(cmd_operand), .cmd_ready(cmd_ready), .program_counter(program_counter),
    .bank_change(bank_change), .bank_change_page(bank_change_page),
    .bank_change_code(bank_change_code), .mem_addr(mem_addr), .mem_cs0_n(mem_cs0_n),
    .mem_cs1_n(mem_cs1_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
    .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in));

  mcu_mem_model mcu_mem_model_i (.clock(clock), .slow(slow), .mem_addr(mem_addr),
    .mem_cs0_n(mem_cs0_n), .mem_cs1_n(mem_cs1_n), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
    .mem_dq_in(mem_dq_in));

  ////////////////////////////////////////////////////////////////////////////
  // comparison and verdict
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  // apb transfer: request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdv = prdata;
    erv = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // one command; waits on cmd_ready, then a fixed two falling edges
  task automatic cmd(input logic [55:0] op);
    while (cmd_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
    {cmd_valid, cmd_operand} <= {1'b1, op};
    @(posedge clock);
    cmd_valid <= 0;
    @(negedge clock);
    while (cmd_ready !== 1'b1) @(negedge clock);
    repeat (2) @(negedge clock);
  endtask : cmd

  function automatic logic [55:0] opp(input logic [3:0] c, input logic [23:0] a,
                                      input logic [15:0] d);
    return {8'h00, a, 4'h0, c, d};
  endfunction : opp

  task automatic st(input logic [31:0] x);
    apb(0, `MCU_STATUS_OFS, 0);
    check("status", rdv, x);
  endtask : st

  task automatic pw(input logic [23:0] a, input logic [15:0] d);
    cmd(opp(`MCU_CMD_WR_PHY, a, d));
    xm[a] = d;
  endtask : pw

  task automatic pr(input logic [23:0] a);
    cmd(opp(`MCU_CMD_RD_PHY, a, 16'h0000));
    apb(0, `MCU_HOLD_OFS, 0);
    check("hold phys", rdv, {16'h0000, xm[a]});
  endtask : pr

  // logical write then read, then find the word at the expected physical page
  task automatic lw(input logic [3:0] pg, input logic [1:0] bk, input logic [11:0] ppg);
    logic [11:0] off;
    logic [15:0] d;
    off = 12'($random(seed));
    d   = 16'($random(seed));
    cmd({16'h0000, pg, off, 2'b00, bk, `MCU_CMD_WR_LOG, d});
    xm[{ppg, off}] = d;
    cmd({16'h0000, pg, off, 2'b00, bk, `MCU_CMD_RD_LOG, 16'h0000});
    apb(0, `MCU_HOLD_OFS, 0);
    check("hold logical", rdv, {16'h0000, d});
    pr({ppg, off});
  endtask : lw

  // bank code to bank index: 00 bank1, 01 bank3, 10 bank2, 11 bank4
  function automatic logic [1:0] bidx(input logic [1:0] c);
    return {c[0], c[1]};
  endfunction : bidx

  ////////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the thousand or so cycles the run needs
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    results;
  end

  initial begin
    logic [1:0]  c;
    logic [23:0] pa;
    repeat (16) @(posedge clock);
    rst <= 0;
    apb(0, `MCU_CTRL_OFS, 0);
    check("ctrl reset", rdv, 32'h2);
    st(0);
    apb(0, 8'h10, 0);
    check("unmapped err", {31'h0, erv}, 1);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      pa = {i[0], 23'($random(seed))};
      pw(pa, 16'($random(seed)));
      pr(pa);
    end
    lw(4'h6, 2'b00, 12'h006);
    lw(4'h5, 2'b00, 12'h006);
    lw(4'h5, 2'b11, 12'h005);
    for (int b = 0; b < 4; b++) begin
      pw({18'h20100, 4'h8, 2'(b)}, 16'h8100 + 16'(b));
      pw({18'h20100, 4'h1, 2'(b)}, 16'h8200);
    end
    cmd(opp(`MCU_CMD_GLOBAL_ON, 0, 0));
    st(1);
    for (int k = 0; k < 4; k++) begin
      lw(4'h8, 2'(k), 12'h100 + 12'(bidx(2'(k))));
    end
    cmd(opp(`MCU_CMD_SPECIAL_ON, 0, 0));
    st(3);
    lw(4'h1, 2'b01, 12'h200);
    $display("translation test done");
    cmd(opp(`MCU_CMD_SPECIAL_OFF, 0, 0));
    cmd(opp(`MCU_CMD_GLOBAL_OFF, 0, 0));
    st(32'hf);
    lw(4'h1, 2'b00, 12'h200);
    @(posedge clock);
    program_counter <= 16'h2abc;
    repeat (3) @(posedge clock);
    st(0);
    lw(4'h1, 2'b00, 12'h001);
    lw(4'h8, 2'b10, 12'h008);
    cmd(opp(`MCU_CMD_SPECIAL_ON, 0, 0));
    lw(4'h1, 2'b00, 12'h001);
    for (int u = 0; u < 14; u++) begin
      if (u < 2 || u > 7) cmd(opp(4'(u), 24'h000123, 16'hffff));
    end
    st(2);
    $display("disable test done");
    xbank = 0;
    for (int p = 5; p < 16; p++) begin
      c = 2'($random(seed));
      @(posedge clock);
      {bank_change, bank_change_page, bank_change_code} <= {1'b1, 4'(p), c};
      @(posedge clock);
      bank_change <= 0;
      xbank[2 * (p < 8 ? p - 5 : 3 + (p - 8) / 2) +: 2] = bidx(c);
    end
    repeat (2) @(posedge clock);
    apb(0, `MCU_BANK_OFS, 0);
    check("banks", rdv, xbank);
    apb(1, `MCU_CTRL_OFS, 32'h6);
    slow <= 1;
    pw(24'h812345, 16'h5a3c);
    pr(24'h812345);
    slow <= 0;
    rst <= 1;
    repeat (3) @(posedge clock);
    rst <= 0;
    st(0);
    $display("bank and reset test done");
    results;
  end
endmodule : mcu_mem_cmd_tb
